// ==== hdl/tsf_fifo.sv ====
// Temperature sample queue with its register port and almost-full flag
`timescale 1ns/100ps
`default_nettype none
module tsf_fifo (
  input wire logic core_clk,
  input wire logic nrst,
  input wire tsf_pkg::tsf_sample_s sample_in,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire tsf_pkg::tsf_reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  output logic afull_flag,
  input wire logic afull_int_en,
  input wire logic [1:0] pin_zero_function,
  output logic pin_zero_irq
);
  typedef struct packed {
    logic [tsf_pkg::DEPTH-1:0][tsf_pkg::SAMPLE_W-1:0] mem;
    logic [tsf_pkg::IDX_W-1:0] wr_idx;
    logic [tsf_pkg::IDX_W-1:0] rd_idx;
    logic [tsf_pkg::IDX_W-1:0] lost;
    logic [tsf_pkg::CNT_W-1:0] avail;
    logic [tsf_pkg::IDX_W-1:0] wmark;
    logic flush;
    logic clr_on_data;
    logic afull_type;
    logic roll;
    logic low_byte;
    logic afull;
    logic [7:0] rdata;
  } tsf_core_state_s;

  tsf_core_state_s s;
  tsf_core_state_s next_s;
  tsf_pkg::tsf_sample_s buf_data;
  logic buf_valid;
  logic drain_ready;
  logic push;
  logic pop;
  logic data_rd;
  logic stat_rd;
  logic rd_write;
  logic full_now;
  logic roll_over;
  logic drop;
  logic afull_set;
  logic afull_clear;
  logic [tsf_pkg::CNT_W-1:0] thr;
  logic [tsf_pkg::CNT_W-1:0] avail_pop;
  logic [7:0] hi_byte;

  // Samples wait here while a flush holds the queue
  tsf_pair_buf #(
    .WIDTH($bits(tsf_pkg::tsf_sample_s))
  ) u_pair_buf (
    .core_clk(core_clk),
    .nrst(nrst),
    .in_data(sample_in),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .out_data(buf_data),
    .out_valid(buf_valid),
    .out_ready(drain_ready)
  );

  // Access decode and the almost-full threshold
  assign drain_ready = !s.flush;
  assign push = buf_valid && drain_ready;
  assign data_rd = reg_req.rd && (reg_req.addr == tsf_pkg::OFS_DATA);
  assign stat_rd = reg_req.rd && (reg_req.addr == tsf_pkg::OFS_STATUS);
  assign rd_write = reg_req.wr && (reg_req.addr == tsf_pkg::OFS_RD_IDX);
  assign pop = data_rd && s.low_byte; // RQ6
  assign thr = tsf_pkg::FULL_COUNT - {1'b0, s.wmark}; // RQ9
  assign hi_byte = s.mem[s.rd_idx][15:8];

  // Queue update; one push and one register access per cycle
  always_comb begin
    next_s = s;
    avail_pop = s.avail;
    full_now = 1'b0;
    roll_over = 1'b0;
    drop = 1'b0;
    afull_set = 1'b0;
    afull_clear = 1'b0;
    // Register reads answer on the next edge
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        tsf_pkg::OFS_WR_IDX: next_s.rdata = {3'h0, s.wr_idx};
        tsf_pkg::OFS_RD_IDX: next_s.rdata = {3'h0, s.rd_idx};
        tsf_pkg::OFS_LOST: next_s.rdata = {3'h0, s.lost};
        tsf_pkg::OFS_AVAIL: next_s.rdata = {2'h0, s.avail};
        tsf_pkg::OFS_WMARK: next_s.rdata = {3'h0, s.wmark};
        tsf_pkg::OFS_QCFG: begin
          next_s.rdata = {3'h0, s.flush, s.clr_on_data, s.afull_type,
            s.roll, 1'b0};
        end
        tsf_pkg::OFS_DATA: begin
          if (!s.low_byte) begin
            next_s.rdata = hi_byte; // RQ7
          end else begin
            next_s.rdata = s.mem[s.rd_idx][7:0]; // RQ7
          end
        end
        default: next_s.rdata = tsf_pkg::RST_BYTE;
      endcase
    end
    // Byte pairing; the second byte pops the word
    if (data_rd) begin
      next_s.low_byte = ~s.low_byte;
    end
    if (pop) begin
      next_s.rd_idx = s.rd_idx + tsf_pkg::IDX_STEP; // RQ2 RQ6
      next_s.lost = tsf_pkg::RST_IDX; // RQ4
      if (s.avail != tsf_pkg::RST_CNT) begin
        avail_pop = s.avail - tsf_pkg::CNT_STEP; // RQ5
      end
    end
    next_s.avail = avail_pop;
    // Count, not index equality, decides full
    full_now = (avail_pop == tsf_pkg::FULL_COUNT); // RQ8
    if (push) begin
      if (!full_now) begin
        next_s.mem[s.wr_idx] = buf_data.temp; // RQ20
        next_s.wr_idx = s.wr_idx + tsf_pkg::IDX_STEP; // RQ1
        next_s.avail = avail_pop + tsf_pkg::CNT_STEP; // RQ5
      end else if (s.roll) begin
        roll_over = 1'b1;
        next_s.mem[s.wr_idx] = buf_data.temp; // RQ11
        next_s.wr_idx = s.wr_idx + tsf_pkg::IDX_STEP; // RQ11
        next_s.rd_idx = next_s.rd_idx + tsf_pkg::IDX_STEP; // RQ11
      end else begin
        drop = 1'b1; // RQ12
      end
      // Lost words count after the pop clear, so neither is missed
      if (full_now && (s.lost != tsf_pkg::LOST_MAX)) begin
        next_s.lost = next_s.lost + tsf_pkg::IDX_STEP; // RQ3
      end else if (full_now) begin
        next_s.lost = tsf_pkg::LOST_MAX; // RQ3
      end
    end
    // Almost-full flag; a set in the clearing cycle wins
    if (push && (next_s.avail >= thr)) begin
      afull_set = !s.afull_type || (avail_pop < thr); // RQ13 RQ14
    end
    afull_clear = stat_rd || (data_rd && s.clr_on_data); // RQ15 RQ16
    next_s.afull = afull_set || (s.afull && !afull_clear); // RQ9
    // Register writes
    if (rd_write) begin
      next_s.rd_idx = reg_req.wdata[4:0]; // RQ2
      next_s.low_byte = 1'b0;
    end
    if (reg_req.wr && (reg_req.addr == tsf_pkg::OFS_WMARK)) begin
      next_s.wmark = reg_req.wdata[4:0];
    end
    if (reg_req.wr && (reg_req.addr == tsf_pkg::OFS_QCFG)) begin
      next_s.flush = reg_req.wdata[tsf_pkg::QCFG_FLUSH_BIT]; // RQ21
      next_s.clr_on_data = reg_req.wdata[tsf_pkg::QCFG_CLR_BIT]; // RQ21
      next_s.afull_type = reg_req.wdata[tsf_pkg::QCFG_TYPE_BIT]; // RQ21
      next_s.roll = reg_req.wdata[tsf_pkg::QCFG_ROLL_BIT]; // RQ21
    end
    // Flush takes one cycle and clears itself; samples wait meanwhile
    if (s.flush) begin
      next_s.wr_idx = tsf_pkg::RST_IDX; // RQ17
      next_s.rd_idx = tsf_pkg::RST_IDX; // RQ17
      next_s.avail = tsf_pkg::RST_CNT; // RQ17
      next_s.lost = tsf_pkg::RST_IDX; // RQ17
      next_s.low_byte = 1'b0;
      next_s.flush = 1'b0; // RQ17
    end
  end

  // All reset values are zero: queue empty, counters cleared
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s <= '0; // RQ22
    end else begin
      s <= next_s;
    end
  end

  // Outputs; the pin follows the flag while routing allows it
  assign reg_rdata = s.rdata;
  assign afull_flag = s.afull;
  assign pin_zero_irq = s.afull && afull_int_en &&
    (pin_zero_function == tsf_pkg::PIN_ZERO_IRQ_MODE); // RQ10

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  sequence low_byte_read;
    data_rd && s.low_byte && !s.flush && !rd_write && !roll_over;
  endsequence

  sequence flush_request;
    reg_req.wr && (reg_req.addr == tsf_pkg::OFS_QCFG) &&
      reg_req.wdata[tsf_pkg::QCFG_FLUSH_BIT] && !s.flush;
  endsequence

  sequence queue_cleared;
    (s.wr_idx == tsf_pkg::RST_IDX) && (s.rd_idx == tsf_pkg::RST_IDX) &&
      (s.avail == tsf_pkg::RST_CNT) && (s.lost == tsf_pkg::RST_IDX) &&
      !s.flush;
  endsequence

  write_index_step_a: assert property ( // RQ1
    push && !drop |=> s.wr_idx == $past(s.wr_idx) + tsf_pkg::IDX_STEP)
    else $error("write index did not advance by one");
  read_index_step_a: assert property ( // RQ6
    low_byte_read |=> s.rd_idx == $past(s.rd_idx) + tsf_pkg::IDX_STEP)
    else $error("word pop did not advance read index by one");
  lost_saturate_a: assert property ( // RQ3
    s.lost == tsf_pkg::LOST_MAX && !pop && !s.flush |=>
      s.lost == tsf_pkg::LOST_MAX)
    else $error("lost count left saturation");
  lost_clear_a: assert property ( // RQ4
    pop && !full_now && !s.flush |=> s.lost == tsf_pkg::RST_IDX)
    else $error("lost count not zeroed on pop");
  avail_bound_a: assert property ( // RQ8
    s.avail <= tsf_pkg::FULL_COUNT)
    else $error("available count above depth");
  drop_keeps_a: assert property ( // RQ12
    drop && !s.flush |=> $stable(s.wr_idx) &&
      s.avail == tsf_pkg::FULL_COUNT)
    else $error("dropped sample changed the queue");
  flush_clears_a: assert property ( // RQ17
    flush_request |=> s.flush ##1 queue_cleared)
    else $error("flush did not empty the queue");
  high_first_a: assert property ( // RQ7
    data_rd && !s.low_byte && !s.flush |=>
      reg_rdata == $past(hi_byte) && s.low_byte)
    else $error("high byte not returned first");
  flag_set_a: assert property ( // RQ13
    afull_set |=> s.afull ##0 (pin_zero_irq || !afull_int_en ||
      pin_zero_function != tsf_pkg::PIN_ZERO_IRQ_MODE))
    else $error("almost-full event lost or not routed");
  reset_empty_a: assert property (disable iff (1'b0) // RQ22
    !nrst |=> s.avail == tsf_pkg::RST_CNT && s.wr_idx == tsf_pkg::RST_IDX &&
      s.rd_idx == tsf_pkg::RST_IDX && s.lost == tsf_pkg::RST_IDX)
    else $error("queue not empty after reset");

  // Pushes into a full queue, whether rolled or dropped
  sequence full_push;
    push && full_now;
  endsequence

  lost_step_a: assert property ( // RQ3
    full_push ##0 (s.lost != tsf_pkg::LOST_MAX) |=>
      s.lost == $past(s.lost) + tsf_pkg::IDX_STEP)
    else $error("lost count missed a word");
  roll_moves_a: assert property ( // RQ11
    full_push ##0 (s.roll && !rd_write) |=>
      s.wr_idx == $past(s.wr_idx) + tsf_pkg::IDX_STEP &&
      s.rd_idx == $past(s.rd_idx) + tsf_pkg::IDX_STEP &&
      s.avail == tsf_pkg::FULL_COUNT)
    else $error("rollover did not overwrite the oldest word");
  drop_still_a: assert property ( // RQ12
    full_push ##0 (!s.roll && !rd_write) |=>
      $stable(s.rd_idx) && $stable(s.mem))
    else $error("dropped sample touched stored words");

  // Words-available count follows single pushes and pops
  avail_up_a: assert property ( // RQ5
    push && !full_now && !pop |=>
      s.avail == $past(s.avail) + tsf_pkg::CNT_STEP)
    else $error("available count missed a push");
  avail_down_a: assert property ( // RQ5
    pop && !push && s.avail != tsf_pkg::RST_CNT && !s.flush |=>
      s.avail == $past(s.avail) - tsf_pkg::CNT_STEP)
    else $error("available count missed a pop");

  // Master writes to the read index land whole and restart the pair
  rd_write_a: assert property ( // RQ2
    rd_write && !s.flush |=> s.rd_idx == $past(reg_req.wdata[4:0]) &&
      !s.low_byte)
    else $error("read index write did not land");

  // Second byte of a word closes the pair
  low_second_a: assert property ( // RQ7
    low_byte_read |=> !s.low_byte &&
      reg_rdata == $past(s.mem[s.rd_idx][7:0]))
    else $error("low byte not returned second");

  // Flag setting at the watermark and clearing by reads
  afull_level_a: assert property ( // RQ9
    push && !full_now && !pop && !s.afull_type &&
      (s.avail + tsf_pkg::CNT_STEP == thr) |=> s.afull)
    else $error("flag not set at the watermark");
  flag_clear_a: assert property ( // RQ16
    afull_clear && !afull_set |=> !s.afull)
    else $error("almost-full flag not cleared by a read");
  flag_keep_a: assert property ( // RQ15
    s.afull && data_rd && !s.clr_on_data |=> s.afull)
    else $error("data read cleared the flag with select low");
  type_high_a: assert property ( // RQ14
    push && s.afull_type && !s.afull && avail_pop >= thr |=> !s.afull)
    else $error("persisting condition set the flag again");

  // Flush lasts one cycle; the write index wraps to zero
  flush_self_clear_a: assert property ( // RQ17
    s.flush |=> !s.flush)
    else $error("flush bit did not clear itself");
  wrap_a: assert property ( // RQ1
    push && !drop && s.wr_idx == '1 |=> s.wr_idx == tsf_pkg::RST_IDX)
    else $error("write index did not wrap to zero");
endmodule
`default_nettype wire

// ==== hdl/tsf_pair_buf.sv ====
// Two-entry valid/ready buffer in front of the sample queue
`timescale 1ns/100ps
`default_nettype none
module tsf_pair_buf #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] slot;
    logic head;
    logic [1:0] fill;
  } tsf_buf_state_s;

  tsf_buf_state_s s;
  tsf_buf_state_s next_s;
  logic push;
  logic pop;

  // Full at two entries, so a stall upstream costs no word
  assign in_ready = (s.fill != 2'h2);
  assign out_valid = (s.fill != 2'h0);
  assign out_data = s.slot[s.head];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Tail slot is head plus fill, modulo two
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.slot[s.head ^ s.fill[0]] = in_data;
    end
    if (pop) begin
      next_s.head = ~s.head;
    end
    if (push && !pop) begin
      next_s.fill = s.fill + 2'h1;
    end else if (pop && !push) begin
      next_s.fill = s.fill - 2'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  buf_fill_bound_a: assert property (@(posedge core_clk) disable iff (!nrst)
    s.fill <= 2'h2) else $error("pair buffer overfilled");
  buf_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("stalled word changed or vanished");
endmodule
`default_nettype wire

// ==== hdl/tsf_pkg.sv ====
// Constants, carriers and field layout for the temperature sample queue
// What this block does
// RQ1: Five-bit write index, wraps 1F to 00
// RQ2: Writable read index, advances per word, wraps
// RQ3: Saturating five-bit count of lost words
// RQ4: Lost-word count zeroed on each popped word
// RQ5: Six-bit words-available count, up and down
// RQ6: Burst of 2N bytes pops N words
// RQ7: High byte first, then low byte
// RQ8: Count tells empty from full, indices equal
// RQ9: Almost-full at 32 minus watermark words
// RQ10: Flag, enable and pin mode 3 raise pin
// RQ11: Rollover on: full queue overwrites oldest
// RQ12: Rollover off: full queue drops new sample
// RQ13: Type low: flag reasserts every sample
// RQ14: Type high: flag sets only on new condition
// RQ15: Select low: only status read clears flag
// RQ16: Select high: data or status read clears
// RQ17: Flush empties queue, self-clearing bit
// RQ18: Master writes read index with care
// RQ19: Master checks lost count, then available count
// RQ20: Thirty-two entries of sixteen-bit samples
// RQ21: Config bits: flush 4, select 3, type 2, roll 1
// RQ22: Reset leaves queue empty, all counters zero
package tsf_pkg;
  localparam int unsigned DEPTH = 32;
  localparam int unsigned IDX_W = 5;
  localparam int unsigned CNT_W = 6;
  localparam int unsigned SAMPLE_W = 16;
  localparam logic [CNT_W-1:0] FULL_COUNT = 6'h20;
  localparam logic [IDX_W-1:0] LOST_MAX = 5'h1F;
  localparam logic [IDX_W-1:0] IDX_STEP = 5'h01;
  localparam logic [CNT_W-1:0] CNT_STEP = 6'h01;
  // Register offsets on the internal register port
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_WR_IDX = 8'h04;
  localparam logic [7:0] OFS_RD_IDX = 8'h05;
  localparam logic [7:0] OFS_LOST = 8'h06;
  localparam logic [7:0] OFS_AVAIL = 8'h07;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_WMARK = 8'h09;
  localparam logic [7:0] OFS_QCFG = 8'h0A;
  // Field positions in the queue behaviour register
  localparam int unsigned QCFG_FLUSH_BIT = 4;
  localparam int unsigned QCFG_CLR_BIT = 3;
  localparam int unsigned QCFG_TYPE_BIT = 2;
  localparam int unsigned QCFG_ROLL_BIT = 1;
  // Pin function code that routes the almost-full flag out
  localparam logic [1:0] PIN_ZERO_IRQ_MODE = 2'h3;
  // Reset values
  localparam logic [IDX_W-1:0] RST_IDX = 5'h00;
  localparam logic [CNT_W-1:0] RST_CNT = 6'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tsf_reg_req_s;

  typedef struct packed {
    logic [SAMPLE_W-1:0] temp;
  } tsf_sample_s;
endpackage

// ==== tb/test_tsf_fifo.sv ====
// Self-checking bench for the temperature sample queue
`timescale 1ns/100ps
`default_nettype none
module test_tsf_fifo;
  logic core_clk;
  logic nrst;
  tsf_pkg::tsf_sample_s sample_in;
  logic sample_valid;
  logic sample_ready;
  tsf_pkg::tsf_reg_req_s reg_req;
  logic [7:0] reg_rdata;
  logic afull_flag;
  logic afull_int_en;
  logic [1:0] pin_zero_function;
  logic pin_zero_irq;
  int n_errors;
  int checks_done;
  int np;
  logic [7:0] b;
  logic [15:0] w;

  tsf_fifo u_tsf_fifo (
    .core_clk(core_clk),
    .nrst(nrst),
    .sample_in(sample_in),
    .sample_valid(sample_valid),
    .sample_ready(sample_ready),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .afull_flag(afull_flag),
    .afull_int_en(afull_int_en),
    .pin_zero_function(pin_zero_function),
    .pin_zero_irq(pin_zero_irq)
  );

  tsf_bus_master u_tsf_bus_master (
    .core_clk(core_clk),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata)
  );

  // Free-running core clock, 25 ns
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // Distinct high and low bytes expose a swapped byte order
  function automatic logic [15:0] val(input int i);
    return {8'(i) ^ 8'h5A, 8'(i)};
  endfunction

  // Offers n words; waits two edges so the queue state has settled
  task automatic push(input int n);
    repeat (n) begin
      @(posedge core_clk);
      sample_valid <= 1'b1;
      sample_in <= val(np);
      @(posedge core_clk);
      while (sample_ready !== 1'b1) @(posedge core_clk);
      sample_valid <= 1'b0;
      np++;
      repeat (2) @(posedge core_clk);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    u_tsf_bus_master.rd(a, b);
    chk(16'(b), 16'(exp));
  endtask

  task automatic wchk(input logic [15:0] exp);
    u_tsf_bus_master.read_word(w);
    chk(w, exp);
  endtask

  task automatic t_reset();
    chk(16'(afull_flag), 16'h0000);
    chk(16'(sample_ready), 16'h0001);
    for (int a = 4; a < 8; a++) rchk(8'(a), 8'h00);
    rchk(8'h0B, 8'h00);
  endtask

  task automatic t_order();
    push(3);
    rchk(8'h07, 8'h03);
    rchk(8'h04, 8'h03);
    for (int k = 0; k < 3; k++) wchk(val(k));
    rchk(8'h05, 8'h03);
    rchk(8'h07, 8'h00);
    u_tsf_bus_master.wr(8'h05, 8'h00);
    rchk(8'h05, 8'h00);
    wchk(val(0));
    u_tsf_bus_master.wr(8'h05, 8'h03);
  endtask

  // Fill past full with rollover off; two words are dropped
  task automatic t_drop();
    u_tsf_bus_master.wr(8'h09, 8'h02);
    u_tsf_bus_master.wr(8'h0A, 8'h00);
    rchk(8'h09, 8'h02);
    push(29);
    chk(16'(afull_flag), 16'h0000);
    push(1);
    chk(16'(afull_flag), 16'h0001);
    chk(16'(pin_zero_irq), 16'h0001);
    pin_zero_function <= 2'h2;
    @(posedge core_clk);
    chk(16'(pin_zero_irq), 16'h0000);
    pin_zero_function <= 2'h3;
    afull_int_en <= 1'b0;
    @(posedge core_clk);
    chk(16'(pin_zero_irq), 16'h0000);
    afull_int_en <= 1'b1;
    push(4);
    rchk(8'h06, 8'h02);
    rchk(8'h07, 8'h20);
    rchk(8'h04, 8'h03);
    rchk(8'h05, 8'h03);
    wchk(val(3));
    rchk(8'h06, 8'h00);
    chk(16'(afull_flag), 16'h0001);
    u_tsf_bus_master.rd(8'h00, b);
    chk(16'(afull_flag), 16'h0000);
    push(1);
    chk(16'(afull_flag), 16'h0001);
  endtask

  // Rollover on and data reads clearing the flag
  task automatic t_roll();
    u_tsf_bus_master.wr(8'h0A, 8'h0A);
    push(1);
    rchk(8'h06, 8'h01);
    rchk(8'h07, 8'h20);
    wchk(val(5));
    chk(16'(afull_flag), 16'h0000);
    push(33);
    rchk(8'h06, 8'h1F);
  endtask

  task automatic t_flush();
    u_tsf_bus_master.wr(8'h0A, 8'h14);
    rchk(8'h0A, 8'h04);
    for (int a = 4; a < 8; a++) rchk(8'(a), 8'h00);
  endtask

  // Type high: a persisting condition does not set the flag again
  task automatic t_type_high();
    u_tsf_bus_master.rd(8'h00, b);
    push(29);
    chk(16'(afull_flag), 16'h0000);
    push(1);
    chk(16'(afull_flag), 16'h0001);
    u_tsf_bus_master.rd(8'h00, b);
    push(1);
    chk(16'(afull_flag), 16'h0000);
  endtask

  // Reset in mid-run must empty a queue that still holds words
  task automatic t_rerst();
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    for (int a = 4; a < 8; a++) rchk(8'(a), 8'h00);
  endtask

  task automatic end_of_test();
    $display("checks %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Whole run needs about six hundred cycles; the 20000-cycle limit is far beyond it
  initial begin
    #500000;
    n_errors++;
    end_of_test();
  end

  initial begin
    nrst = 1'b0;
    sample_valid = 1'b0;
    sample_in = '0;
    afull_int_en = 1'b1;
    pin_zero_function = 2'h3;
    n_errors = 0;
    checks_done = 0;
    np = 0;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_order();
    t_drop();
    t_roll();
    t_flush();
    t_type_high();
    t_rerst();
    end_of_test();
  end
endmodule
`default_nettype wire

// ==== tb/tsf_bus_master.sv ====
// Register-port master model standing in for the serial bus side
`timescale 1ns/100ps
`default_nettype none
module tsf_bus_master (
  input wire logic core_clk,
  output var tsf_pkg::tsf_reg_req_s reg_req,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_req = '0;
  end

  // One access; address and data are inverted once released
  task automatic access(input logic is_rd, input logic [7:0] a,
                        input logic [7:0] d);
    @(posedge core_clk);
    reg_req <= {is_rd, !is_rd, a, d};
    @(posedge core_clk);
    reg_req <= {1'b0, 1'b0, ~a, ~d};
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    access(1'b0, a, d);
  endtask

  // Read data is registered, so it is taken one edge after the request
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    access(1'b1, a, 8'h00);
    @(posedge core_clk);
    d = reg_rdata;
  endtask

  // A word is always fetched whole, as a two-byte burst from the port
  task automatic read_word(output logic [15:0] w);
    logic [7:0] hi;
    logic [7:0] lo;
    rd(tsf_pkg::OFS_DATA, hi);
    rd(tsf_pkg::OFS_DATA, lo);
    w = {hi, lo};
  endtask
endmodule
`default_nettype wire
